// ### hlc_regs.svh
`ifndef HLC_REGS_SVH
`define HLC_REGS_SVH
`define HLC_ADDR_W 8
`define HLC_OFS_SET 8'h50
`define HLC_OFS_CLR 8'h54
`define HLC_BIT_ENDIAN 30
`define HLC_BIT_OWNER 23
`define HLC_BIT_ENH 22
`define HLC_BIT_LPS 19
`define HLC_BIT_POSTED 18
`define HLC_BIT_ATTACH 17
`define HLC_BIT_REINIT 16
`define HLC_VC_BIT_ENH 1
`define HLC_VC_BIT_OWNER 0
`define HLC_RST_OWNER 1'b1
`define HLC_RST_ENH 1'b0
`define HLC_RST_LPS 1'b0
`define HLC_RST_ATTACH 1'b0
`define HLC_RST_ENDIAN 1'b0
`define HLC_RST_POSTED 1'b0
`define HLC_CLK_PERIOD_NS 20
`define HLC_REINIT_NS 200
`define HLC_REINIT_CYC ((`HLC_REINIT_NS + `HLC_CLK_PERIOD_NS - 1) / `HLC_CLK_PERIOD_NS)
`define HLC_LCLK_IDLE_NS 400
`define HLC_LCLK_IDLE_CYC (`HLC_LCLK_IDLE_NS / `HLC_CLK_PERIOD_NS)
`define HLC_TC_QW_REQ 4'h0
`define HLC_TC_BW_REQ 4'h1
`define HLC_TC_QR_RSP 4'h6
`define HLC_TC_BR_RSP 4'h7
`define HLC_TC_LK_REQ 4'h9
`define HLC_TC_STRM 4'ha
`define HLC_TC_LK_RSP 4'hb
`define HLC_TC_PHY 4'he
`endif

// ### hlc_pkg.sv
package hlc_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } hlc_req_s;
  typedef struct packed {
    logic [3:0] tcode;
    logic is_header;
    logic is_cycle_time;
    logic [31:0] quadlet;
  } hlc_quad_s;
  typedef struct packed {
    logic endian_big;
    logic enh_en;
    logic link_power_on;
    logic posted_en;
    logic attach;
  } hlc_ctl_s;
  typedef enum logic [1:0] {
    HLC_RUN = 2'b01,
    HLC_REINIT = 2'b10
  } hlc_mode_e;
endpackage

// ### hlc_host_control.sv
// How it works
// [R1] endian select 0 sends data quadlets low byte first, 1 high byte first
// [R2] header quadlets always leave high byte first
// [R3] only data crc payloads, quadlet write request and quadlet read response swap
// [R4] cycle timer value and phy packet payload never swap
// [R5] software changes endian and posted bits only while attach is off
// [R6] owner flag is read/clear, hard reset sets it, soft and bus reset keep it
// [R7] owner flag steers no hardware at all
// [R8] enhancement enable resets low, gates all enhancements, survives soft and bus reset
// [R9] driver touches enhancement bit only with owner set and attach off
// [R10] software configures link and phy enhancements alike, then clears owner
// [R11] link power on is set-only, cleared by hard and soft reset
// [R12] with link power off only identity and host control registers are defined
// [R13] posted write bit chooses posting or ack pending for physical writes
// [R14] attach off blocks receive and bus requests but keeps phy register access
// [R15] attach is set-only, cleared only by hard or soft reset
// [R16] software sets attach after rom mapping is valid, then forces bus reset
// [R17] writing reinit resets state, flushes fifos, restores host registers
// [R18] reinit reads one while a soft or hard reset runs
// [R19] both addresses read the register; ones set or clear, zeros ignored
// [R20] order is link power on, then attach, then context run
// [R21] power on lets link clock start; attach then starts a bus reset
// [R22] eeprom may load enhancement bit; vendor control reaches both enhancement bits
// [R23] reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "hlc_regs.svh"
module hlc_host_control (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register access
  input wire hlc_pkg::hlc_req_s req,
  output logic [31:0] rd_data,
  output logic rd_valid,
  // vendor control and eeprom
  input wire logic vc_wr,
  input wire logic [1:0] vc_wdata,
  output logic [1:0] vc_rdata,
  input wire logic eeprom_load,
  input wire logic eeprom_enh,
  // link side
  input wire logic link_clk,
  output logic link_clk_running,
  output logic bus_reset_req,
  output logic fifo_flush,
  output logic reinit_busy,
  output hlc_pkg::hlc_ctl_s ctl,
  output logic rx_enable,
  output logic bus_req_enable,
  output logic phy_reg_access_enable,
  output logic other_regs_defined,
  output logic phy_write_ack_pending,
  // byte order path
  input wire logic q_in_valid,
  input wire hlc_pkg::hlc_quad_s q_in,
  output logic q_out_valid,
  output logic [31:0] q_out
);
  import hlc_pkg::*;

  typedef struct packed {
    hlc_mode_e mode;
    logic [7:0] rst_cnt;
    logic endian;
    logic owner;
    logic enh;
    logic link_power_on;
    logic posted;
    logic attach;
    logic [2:0] lsync;
    logic lclk_q;
    logic [7:0] idle_cnt;
    logic lclk_run;
    logic busrst;
    logic flush;
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] qdata;
    logic qvalid;
  } hlc_state_s;

  localparam logic [7:0] REINIT_CYC = 8'(`HLC_REINIT_CYC);
  localparam logic [7:0] IDLE_CYC = 8'(`HLC_LCLK_IDLE_CYC);

  hlc_state_s s_q;
  hlc_state_s s_d;
  logic [31:0] reg_view;
  logic set_wr;
  logic clr_wr;
  logic swap_class;
  logic lclk_stable;

  always_comb begin
    // reserved bits stay zero [R23]
    reg_view = 32'h0000_0000;
    reg_view[`HLC_BIT_ENDIAN] = s_q.endian;
    reg_view[`HLC_BIT_OWNER] = s_q.owner;
    reg_view[`HLC_BIT_ENH] = s_q.enh;
    reg_view[`HLC_BIT_LPS] = s_q.link_power_on;
    reg_view[`HLC_BIT_POSTED] = s_q.posted;
    reg_view[`HLC_BIT_ATTACH] = s_q.attach;
    reg_view[`HLC_BIT_REINIT] = (s_q.mode == HLC_REINIT); // [R18]
    set_wr = 1'b0;
    clr_wr = 1'b0;
    if (req.wr && req.addr == `HLC_OFS_SET) begin
      set_wr = 1'b1;
    end else if (req.wr && req.addr == `HLC_OFS_CLR) begin
      clr_wr = 1'b1;
    end
    case (q_in.tcode)
      `HLC_TC_QW_REQ, `HLC_TC_BW_REQ, `HLC_TC_QR_RSP, `HLC_TC_BR_RSP,
      `HLC_TC_LK_REQ, `HLC_TC_STRM, `HLC_TC_LK_RSP: swap_class = 1'b1; // [R3]
      default: swap_class = 1'b0; // phy packets fall here [R4]
    endcase
  end

  assign lclk_stable = (s_q.lsync[2] == s_q.lsync[1]);

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.busrst = 1'b0;
    s_d.flush = 1'b0;
    s_d.qvalid = q_in_valid;
    // three-stage sampler; only the agreeing last two stages are used
    s_d.lsync = {s_q.lsync[1:0], link_clk};
    if (lclk_stable && s_q.lsync[2] != s_q.lclk_q) begin
      s_d.lclk_q = s_q.lsync[2];
      s_d.idle_cnt = IDLE_CYC;
      s_d.lclk_run = 1'b1;
    end else if (s_q.idle_cnt != 8'h00) begin
      s_d.idle_cnt = s_q.idle_cnt - 8'h01;
    end else begin
      s_d.lclk_run = 1'b0;
    end
    // reads return the same view at both addresses [R19]
    if (req.rd && (req.addr == `HLC_OFS_SET || req.addr == `HLC_OFS_CLR)) begin
      s_d.rdata = reg_view;
      s_d.rvalid = 1'b1;
    end else if (req.rd) begin
      s_d.rdata = 32'h0000_0000;
      s_d.rvalid = 1'b1;
    end
    case (s_q.mode)
      HLC_REINIT: begin
        // writes during reset are dropped so the restored values hold
        if (s_q.rst_cnt > 8'h01) begin
          s_d.rst_cnt = s_q.rst_cnt - 8'h01;
        end else begin
          s_d.rst_cnt = 8'h00;
          s_d.mode = HLC_RUN;
        end
      end
      default: begin
        if (set_wr) begin
          if (req.wdata[`HLC_BIT_ENDIAN]) s_d.endian = 1'b1; // [R19]
          if (req.wdata[`HLC_BIT_ENH]) s_d.enh = 1'b1; // [R8]
          if (req.wdata[`HLC_BIT_LPS]) s_d.link_power_on = 1'b1; // [R11]
          if (req.wdata[`HLC_BIT_POSTED]) s_d.posted = 1'b1;
          if (req.wdata[`HLC_BIT_ATTACH] && !s_q.attach) begin
            s_d.attach = 1'b1; // [R15]
            s_d.busrst = s_q.link_power_on; // attach starts a bus reset only when link power is on [R21]
          end
          if (req.wdata[`HLC_BIT_REINIT]) begin
            s_d.mode = HLC_REINIT; // [R17]
            s_d.rst_cnt = REINIT_CYC;
            s_d.flush = 1'b1;
            s_d.link_power_on = `HLC_RST_LPS; // [R11]
            s_d.attach = `HLC_RST_ATTACH; // [R15]
            s_d.busrst = 1'b0;
          end
        end else if (clr_wr) begin
          // owner is read/clear; link power and attach cannot be cleared here
          if (req.wdata[`HLC_BIT_ENDIAN]) s_d.endian = 1'b0;
          if (req.wdata[`HLC_BIT_OWNER]) s_d.owner = 1'b0; // [R6]
          if (req.wdata[`HLC_BIT_ENH]) s_d.enh = 1'b0;
          if (req.wdata[`HLC_BIT_POSTED]) s_d.posted = 1'b0;
        end else if (vc_wr) begin
          s_d.enh = vc_wdata[`HLC_VC_BIT_ENH]; // [R22]
          if (!vc_wdata[`HLC_VC_BIT_OWNER]) s_d.owner = 1'b0;
        end else if (eeprom_load) begin
          s_d.enh = eeprom_enh; // [R22]
        end
      end
    endcase
    // header, cycle timer and phy data keep high byte first [R2] [R4]
    if (q_in.is_header || q_in.is_cycle_time || !swap_class || s_q.endian) begin
      s_d.qdata = q_in.quadlet; // [R1]
    end else begin
      s_d.qdata = {q_in.quadlet[7:0], q_in.quadlet[15:8], q_in.quadlet[23:16], q_in.quadlet[31:24]}; // [R1]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.mode <= HLC_REINIT; // [R18]
      s_q.rst_cnt <= REINIT_CYC;
      s_q.owner <= `HLC_RST_OWNER; // [R6]
      s_q.enh <= `HLC_RST_ENH; // [R8]
      s_q.link_power_on <= `HLC_RST_LPS;
      s_q.attach <= `HLC_RST_ATTACH;
      s_q.endian <= `HLC_RST_ENDIAN;
      s_q.posted <= `HLC_RST_POSTED;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rdata;
  assign rd_valid = s_q.rvalid;
  assign vc_rdata = {s_q.enh, s_q.owner};
  assign link_clk_running = s_q.lclk_run;
  assign bus_reset_req = s_q.busrst;
  assign fifo_flush = s_q.flush;
  assign reinit_busy = (s_q.mode == HLC_REINIT);
  // owner flag drives none of these [R7]
  assign ctl = '{endian_big: s_q.endian, enh_en: s_q.enh, link_power_on: s_q.link_power_on,
                 posted_en: s_q.posted, attach: s_q.attach};
  assign rx_enable = s_q.attach; // [R14]
  assign bus_req_enable = s_q.attach && s_q.link_power_on; // [R14]
  assign phy_reg_access_enable = s_q.link_power_on; // [R14]
  assign other_regs_defined = s_q.link_power_on; // [R12]
  assign phy_write_ack_pending = !s_q.posted; // [R13]
  assign q_out_valid = s_q.qvalid;
  assign q_out = s_q.qdata;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_set_write(int b);
    req.wr && req.addr == `HLC_OFS_SET && req.wdata[b] && !reinit_busy;
  endsequence
  sequence s_clr_write(int b);
    req.wr && req.addr == `HLC_OFS_CLR && req.wdata[b] && !reinit_busy;
  endsequence

  property p_lps_sticky;
    $fell(ctl.link_power_on) |-> $past(reinit_busy) || reinit_busy;
  endproperty
  a_lps_sticky: assert property (p_lps_sticky) else $error("link power on cleared outside reset"); // [R11]

  property p_attach_set;
    s_set_write(`HLC_BIT_ATTACH) ##0 !req.wdata[`HLC_BIT_REINIT] |=> ctl.attach;
  endproperty
  a_attach_set: assert property (p_attach_set) else $error("attach not set by write"); // [R15]

  property p_attach_no_clear;
    s_clr_write(`HLC_BIT_ATTACH) ##0 ctl.attach |=> ctl.attach;
  endproperty
  a_attach_no_clear: assert property (p_attach_no_clear) else $error("attach cleared by software"); // [R15]

  property p_owner_clear;
    s_clr_write(`HLC_BIT_OWNER) |=> !vc_rdata[0] ##1 !vc_rdata[0];
  endproperty
  a_owner_clear: assert property (p_owner_clear) else $error("owner flag not cleared"); // [R6]

  property p_reinit_span;
    s_set_write(`HLC_BIT_REINIT) |=> reinit_busy [*8] ##1 reinit_busy [*2] ##1 !reinit_busy;
  endproperty
  a_reinit_span: assert property (p_reinit_span) else $error("reinit busy span wrong"); // [R18]

  property p_reinit_flush;
    s_set_write(`HLC_BIT_REINIT) |=> fifo_flush && !ctl.link_power_on && !ctl.attach;
  endproperty
  a_reinit_flush: assert property (p_reinit_flush) else $error("reinit did not flush and clear"); // [R17]

  property p_read_view;
    req.rd && req.addr == `HLC_OFS_CLR |=> rd_valid && rd_data[`HLC_BIT_ATTACH] == ctl.attach
      && rd_data[15:0] == 16'h0000;
  endproperty
  a_read_view: assert property (p_read_view) else $error("read view wrong"); // [R19]

  property p_header_order;
    q_in_valid && q_in.is_header |=> q_out_valid && q_out == $past(q_in.quadlet);
  endproperty
  a_header_order: assert property (p_header_order) else $error("header quadlet swapped"); // [R2]

  property p_little_data;
    q_in_valid && !q_in.is_header && !q_in.is_cycle_time && q_in.tcode == `HLC_TC_QW_REQ && !ctl.endian_big
      |=> q_out[7:0] == $past(q_in.quadlet[31:24]);
  endproperty
  a_little_data: assert property (p_little_data) else $error("data not swapped"); // [R1]

  property p_phy_no_swap;
    q_in_valid && q_in.tcode == `HLC_TC_PHY |=> q_out == $past(q_in.quadlet);
  endproperty
  a_phy_no_swap: assert property (p_phy_no_swap) else $error("phy payload swapped"); // [R4]

  property p_bus_gate;
    !ctl.attach |-> !rx_enable && !bus_req_enable;
  endproperty
  a_bus_gate: assert property (p_bus_gate) else $error("bus activity while detached"); // [R14]

  // a set write must never bring the owner flag back
  property p_owner_no_set;
    s_set_write(`HLC_BIT_OWNER) ##0 !vc_rdata[0] |=> !vc_rdata[0];
  endproperty
  a_owner_no_set: assert property (p_owner_no_set) else $error("owner flag set by write"); // [R6]

  property p_reserved_zero;
    rd_valid |-> rd_data[31] == 1'b0 && rd_data[29:24] == 6'h00 && rd_data[21:20] == 2'h0 && rd_data[15:0] == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // [R23]

  property p_busrst_pulse;
    bus_reset_req |-> ctl.attach && ctl.link_power_on ##1 !bus_reset_req;
  endproperty
  a_busrst_pulse: assert property (p_busrst_pulse) else $error("bus reset pulse wrong"); // [R21]
endmodule
`default_nettype wire

// ### hlc_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module hlc_phy_model (
  // power request from the link
  input wire logic link_power_on,
  // clock handed to the link
  output logic link_clk
);
  // the clock stands still low until link power on is granted
  initial link_clk = 1'b0;
  always #80 link_clk = link_power_on ? ~link_clk : 1'b0;
endmodule
`default_nettype wire

// ### hlc_host_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hlc_host_control_tb;
  import hlc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  hlc_req_s req = '0;
  hlc_quad_s q_in = '0;
  logic q_in_valid = 1'b0;
  logic vc_wr = 1'b0;
  logic eeprom_load = 1'b0;
  logic eeprom_enh = 1'b1;
  logic [1:0] vc_wdata = 2'h0;
  logic [1:0] vc_rdata;
  logic [31:0] rd_data, q_out;
  logic rd_valid, link_clk, link_clk_running, bus_reset_req, fifo_flush, reinit_busy, rx_enable;
  logic bus_req_enable, phy_reg_access_enable, other_regs_defined, phy_write_ack_pending, q_out_valid;
  hlc_ctl_s ctl;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_brq = 0;
  int n_flush = 0;
  hlc_host_control hlc_host_control_i (.ref_clk, .rst, .req, .rd_data, .rd_valid, .vc_wr, .vc_wdata,
    .vc_rdata, .eeprom_load, .eeprom_enh, .link_clk, .link_clk_running, .bus_reset_req, .fifo_flush,
    .reinit_busy, .ctl, .rx_enable, .bus_req_enable, .phy_reg_access_enable, .other_regs_defined,
    .phy_write_ack_pending, .q_in_valid, .q_in, .q_out_valid, .q_out);
  hlc_phy_model hlc_phy_model_i (.link_power_on(ctl.link_power_on), .link_clk(link_clk));
  always #10 ref_clk = ~ref_clk;
  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // pulses are counted so that a doubled pulse shows too
  always @(posedge ref_clk) begin
    cyc++;
    if (bus_reset_req === 1'b1) n_brq++;
    if (fifo_flush === 1'b1) n_flush++;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    req = '{1'b0, 1'b1, a, d};
    @(negedge ref_clk);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    req = '{1'b1, 1'b0, a, 32'h0};
    @(negedge ref_clk);
    req = '0;
    chb("rd_valid", 1'b1, rd_valid);
    chk("rd_data", e, rd_data);
  endtask
  task automatic quad(input logic [3:0] tc, input logic h, input logic ct, input logic sw);
    @(negedge ref_clk);
    q_in_valid = 1'b1;
    q_in = '{tc, h, ct, 32'h11223344};
    @(negedge ref_clk);
    q_in_valid = 1'b0;
    chb("q_out_valid", 1'b1, q_out_valid);
    chk("q_out", sw ? 32'h44332211 : 32'h11223344, q_out);
  endtask
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 60 && reinit_busy !== v; i++) @(negedge ref_clk);
    chb("reinit_busy", v, reinit_busy);
  endtask
  task automatic wait_run(input logic v);
    for (int i = 0; i < 80 && link_clk_running !== v; i++) @(negedge ref_clk);
    chb("link_clk_running", v, link_clk_running);
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    rd(8'h50, 32'h00810000);
    wr(8'h50, 32'h00080000);
    wait_busy(1'b0);
    rd(8'h54, 32'h00800000);
    $display("test reset done");
    wr(8'h50, 32'hfff4ffff);
    wr(8'h58, 32'hffffffff);
    rd(8'h50, 32'h40c40000);
    rd(8'h40, 32'h0);
    chb("ack_pending", 1'b0, phy_write_ack_pending);
    wr(8'h54, 32'hbfb4ffff);
    wr(8'h50, 32'h00800000);
    rd(8'h54, 32'h40400000);
    chb("ack_pending", 1'b1, phy_write_ack_pending);
    chk("vc_rdata", 32'h2, {30'h0, vc_rdata});
    $display("test set clear done");
    for (int t = 0; t < 16; t++) quad(t[3:0], 1'b0, 1'b0, 1'b0);
    wr(8'h54, 32'h40000000);
    for (int t = 0; t < 16; t++) quad(t[3:0], 1'b0, 1'b0, t inside {0, 1, 6, 7, 9, 10, 11});
    quad(4'h1, 1'b1, 1'b0, 1'b0);
    quad(4'h0, 1'b0, 1'b1, 1'b0);
    $display("test byte order done");
    @(negedge ref_clk);
    vc_wr = 1'b1;
    @(negedge ref_clk);
    vc_wr = 1'b0;
    rd(8'h50, 32'h0);
    eeprom_load = 1'b1;
    @(negedge ref_clk);
    eeprom_load = 1'b0;
    @(negedge ref_clk);
    chb("enh_en", 1'b1, ctl.enh_en);
    // vendor write and eeprom load together: the vendor write wins
    vc_wdata = 2'h3;
    eeprom_enh = 1'b0;
    vc_wr = 1'b1;
    eeprom_load = 1'b1;
    @(negedge ref_clk);
    vc_wr = 1'b0;
    eeprom_load = 1'b0;
    @(negedge ref_clk);
    chk("vc_rdata", 32'h2, {30'h0, vc_rdata});
    $display("test enhancement done");
    chb("regs_defined", 1'b0, other_regs_defined);
    wait_run(1'b0);
    wr(8'h50, 32'h00080000);
    chb("phy_access", 1'b1, phy_reg_access_enable);
    chb("regs_defined", 1'b1, other_regs_defined);
    wr(8'h54, 32'h00080000);
    chb("lps", 1'b1, ctl.link_power_on);
    wait_run(1'b1);
    chb("rx_enable", 1'b0, rx_enable);
    chb("bus_req_enable", 1'b0, bus_req_enable);
    wr(8'h50, 32'h00020000);
    repeat (2) @(negedge ref_clk);
    chk("bus_reset_req", 32'h1, n_brq);
    chb("rx_enable", 1'b1, rx_enable);
    chb("bus_req_enable", 1'b1, bus_req_enable);
    wr(8'h54, 32'h00020000);
    rd(8'h50, 32'h004a0000);
    $display("test power attach done");
    wr(8'h50, 32'h00010000);
    repeat (2) @(negedge ref_clk);
    chk("fifo_flush", 32'h1, n_flush);
    rd(8'h50, 32'h00410000);
    wait_busy(1'b0);
    rd(8'h54, 32'h00400000);
    wait_run(1'b0);
    $display("test soft reset done");
    complete_run();
  end
endmodule
`default_nettype wire
